// ### hw/mps_regs.sv
`timescale 1ns/1ps
`include "mps_map.svh"
module mps_regs #(
    // 1: page writable only in special modes, reset 0x3c
    parameter bit PAGE_WR_SPECIAL_ONLY = 1'b0
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire mps_pkg::mps_addr_t paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // integration switches
    input  wire logic               register_space_switch,
    input  wire logic [1:0]         eeprom_alloc_switch,
    input  wire logic [2:0]         ram_alloc_switch,
    input  wire logic               fixed_space_alloc_switch_hi,
    input  wire logic               fixed_space_alloc_switch_lo,
    input  wire logic               paging_partition_switch_hi,
    input  wire logic               paging_partition_switch_lo,
    // mode and control bits from the mapping unit
    input  wire logic               special_mode,
    input  wire logic               ram_high_align,
    input  wire logic               flash_upper_half_only,
    // call and return private path
    input  wire logic               call_wr_en,
    input  wire mps_pkg::mps_page_t call_wr_data,
    output mps_pkg::mps_page_t      call_rd_data,
    // decoded outputs
    output mps_pkg::mps_page_t      program_page_index,
    output logic                    page_window_internal,
    output logic [15:0]             ram_reset_base,
    output logic [3:0]              ram_pos_lsb,
    output logic                    ram_align_high,
    output logic [2:0]              fixed_16k_units,
    output logic                    lower_half_blocked
);
    import mps_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register images

    localparam mps_page_t PAGE_RST = PAGE_WR_SPECIAL_ONLY ?
        `MPS_PAGE_RST_SPC : `MPS_PAGE_RST_ANY;

    logic [1:0] rom_sw;
    logic [1:0] part_sw;
    mps_byte_t  size_a;
    mps_byte_t  size_b;
    mps_byte_t  page_rd;

    assign rom_sw  = {fixed_space_alloc_switch_hi,
                      fixed_space_alloc_switch_lo};
    assign part_sw = {paging_partition_switch_hi,
                      paging_partition_switch_lo};

    // switch mirrors; no storage, so writes cannot touch them
    always_comb begin
        size_a = 8'h00;
        size_a[`MPS_A_REG_BIT] = register_space_switch;
        size_a[`MPS_A_EEP_LSB +: 2] = eeprom_alloc_switch;
        size_a[2:0] = ram_alloc_switch;
        size_b = 8'h00;
        size_b[`MPS_B_ROM_LSB +: 2] = rom_sw;
        size_b[1:0] = part_sw;
    end

    ////////////////////////////////////////////////////////////////////
    // bus decode

    mps_state_s st_q;
    mps_state_s st_d;
    logic       setup;
    logic       wr_fire;
    logic       wr_allowed;

    assign setup   = psel && !penable;
    // zero-wait slave; nothing ever faults
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_fire = psel && penable && pwrite && pstrb[0] &&
                     (paddr == `MPS_OFF_PAGE);
    assign wr_allowed = !PAGE_WR_SPECIAL_ONLY || special_mode;
    assign page_rd = {2'b00, st_q.page};

    ////////////////////////////////////////////////////////////////////
    // next state

    // read data is latched in setup so it stands for the access phase
    always_comb begin
        st_d = st_q;
        if (setup && !pwrite) begin
            if (paddr == `MPS_OFF_SIZE_A) begin
                st_d.rdata = size_a;
            end else if (paddr == `MPS_OFF_SIZE_B) begin
                st_d.rdata = size_b;
            end else if (paddr == `MPS_OFF_PAGE) begin
                st_d.rdata = page_rd;
            end else begin
                st_d.rdata = 8'h00;
            end
        end
        // a waiting bus write lands one edge after it was taken
        if (st_q.pend_v) begin
            st_d.page   = st_q.pend;
            st_d.pend_v = 1'b0;
        end
        // a new bus write only parks; upper bits are dropped
        if (wr_fire && wr_allowed) begin
            st_d.pend_v = 1'b1;
            st_d.pend   = pwdata[5:0];
        end
        // the instruction path wins: it must finish inside its cycle
        if (call_wr_en) begin
            st_d.page   = call_wr_data;
            st_d.pend_v = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.page   <= PAGE_RST;
            st_q.pend_v <= 1'b0;
            st_q.pend   <= 6'h00;
            st_q.rdata  <= 8'h00;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata             = {24'h000000, st_q.rdata};
    // plain binary page number, no remapping
    assign program_page_index = st_q.page;
    assign call_rd_data       = st_q.page;

    // window class and memory map decode
    mps_window_decode u_dec (
        .partition_sw          (part_sw),
        .ram_sw                (ram_alloc_switch),
        .rom_sw                (rom_sw),
        .page                  (st_q.page),
        .ram_high_align        (ram_high_align),
        .flash_upper_half_only (flash_upper_half_only),
        .internal              (page_window_internal),
        .ram_reset_base        (ram_reset_base),
        .ram_pos_lsb           (ram_pos_lsb),
        .ram_align_high        (ram_align_high),
        .fixed_16k_units       (fixed_16k_units),
        .lower_half_blocked    (lower_half_blocked)
    );

    ////////////////////////////////////////////////////////////////////
    // assertions

    property p_size_a_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `MPS_OFF_SIZE_A) |=>
            (prdata[7:0] == $past(size_a)) && prdata[6] == 1'b0;
    endproperty
    a_size_a_read: assert property (p_size_a_read)
        else $error("size A read data wrong");

    property p_reg_bit;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `MPS_OFF_SIZE_A) |=>
            prdata[7] == $past(register_space_switch);
    endproperty
    a_reg_bit: assert property (p_reg_bit)
        else $error("register space bit wrong");

    property p_size_b_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `MPS_OFF_SIZE_B) |=>
            prdata[5:2] == 4'h0 && prdata[7:6] == $past(rom_sw) &&
            prdata[1:0] == $past(part_sw);
    endproperty
    a_size_b_read: assert property (p_size_b_read)
        else $error("size B read data wrong");

    property p_page_read;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `MPS_OFF_PAGE) |=>
            prdata[7:6] == 2'b00 && prdata[5:0] == $past(st_q.page);
    endproperty
    a_page_read: assert property (p_page_read)
        else $error("page read data wrong");

    property p_wr_delay;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && wr_allowed && !call_wr_en) ##1 !call_wr_en |=>
            program_page_index == $past(pwdata[5:0], 2);
    endproperty
    a_wr_delay: assert property (p_wr_delay)
        else $error("page write did not land a cycle later");

    property p_wr_old_kept;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && !call_wr_en && !st_q.pend_v) |=>
            $stable(program_page_index);
    endproperty
    a_wr_old_kept: assert property (p_wr_old_kept)
        else $error("page changed in the write cycle");

    property p_call_path;
        @(posedge pclk) disable iff (!presetn)
        call_wr_en |=> program_page_index == $past(call_wr_data);
    endproperty
    a_call_path: assert property (p_call_path)
        else $error("call path update late or wrong");

    property p_wr_blocked;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && PAGE_WR_SPECIAL_ONLY && !special_mode &&
         !call_wr_en && !st_q.pend_v) |=>
            $stable(program_page_index) ##1 $stable(program_page_index);
    endproperty
    a_wr_blocked: assert property (p_wr_blocked)
        else $error("page written outside special mode");

    property p_internal;
        @(posedge pclk) disable iff (!presetn)
        (part_sw == 2'b01) |->
            page_window_internal == (program_page_index >= 6'h30);
    endproperty
    a_internal: assert property (p_internal)
        else $error("window class wrong for partition 01");

    property p_no_fault;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable) |-> pready && !pslverr;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("bus fault raised");

    property p_ram_base;
        @(posedge pclk) disable iff (!presetn)
        (ram_alloc_switch == 3'b100) |->
            ram_reset_base == 16'h1800 && ram_pos_lsb == 4'he;
    endproperty
    a_ram_base: assert property (p_ram_base)
        else $error("ram base wrong for code 100");

    property p_rom_gate;
        @(posedge pclk) disable iff (!presetn)
        (rom_sw == 2'b01) |-> !lower_half_blocked &&
            fixed_16k_units == 3'h1;
    endproperty
    a_rom_gate: assert property (p_rom_gate)
        else $error("16K fixed space wrongly gated");

    c_page_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_fire ##2 program_page_index == 6'h3f);
    c_call_over_bus: cover property (@(posedge pclk)
        disable iff (!presetn) st_q.pend_v && call_wr_en);
    c_size_read: cover property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && paddr == `MPS_OFF_SIZE_B);
endmodule : mps_regs

// ### hw/mps_map.svh
`ifndef MPS_MAP_SVH
`define MPS_MAP_SVH

// register byte offsets on the bus
`define MPS_OFF_SIZE_A     12'h000
`define MPS_OFF_SIZE_B     12'h004
`define MPS_OFF_PAGE       12'h008
// field positions
`define MPS_A_REG_BIT      7
`define MPS_A_EEP_LSB      4
`define MPS_B_ROM_LSB      6
// page register reset values for the two write options
`define MPS_PAGE_RST_ANY   6'h00
`define MPS_PAGE_RST_SPC   6'h3c
// internal page thresholds per partition code
`define MPS_THR_P00        6'h38
`define MPS_THR_P01        6'h30
`define MPS_THR_P10        6'h20
`define MPS_THR_P11        6'h00
// ram reset base addresses per ram code
`define MPS_RAM_B000       16'h0800
`define MPS_RAM_B001       16'h0000
`define MPS_RAM_B010       16'h0800
`define MPS_RAM_B011       16'h0000
`define MPS_RAM_B100       16'h1800
`define MPS_RAM_B101       16'h1000
`define MPS_RAM_B110       16'h0800
`define MPS_RAM_B111       16'h0000
`endif

// ### hw/mps_pkg.sv
package mps_pkg;
    typedef logic [5:0]  mps_page_t;
    typedef logic [7:0]  mps_byte_t;
    typedef logic [11:0] mps_addr_t;

    // whole register-bank state
    typedef struct packed {
        mps_page_t page;     // live page index
        logic      pend_v;   // bus write waiting to land
        mps_page_t pend;     // value of that write
        mps_byte_t rdata;    // read data for the access phase
    } mps_state_s;
endpackage : mps_pkg

// ### hw/mps_window_decode.sv
`timescale 1ns/1ps
`include "mps_map.svh"
module mps_window_decode (
    // configuration and page
    input  wire logic [1:0]     partition_sw,
    input  wire logic [2:0]     ram_sw,
    input  wire logic [1:0]     rom_sw,
    input  wire mps_pkg::mps_page_t page,
    input  wire logic           ram_high_align,
    input  wire logic           flash_upper_half_only,
    // decoded results
    output logic                internal,
    output logic [15:0]         ram_reset_base,
    output logic [3:0]          ram_pos_lsb,
    output logic                ram_align_high,
    output logic [2:0]          fixed_16k_units,
    output logic                lower_half_blocked
);
    import mps_pkg::*;

    // partition threshold and window class
    always_comb begin
        case (partition_sw)
            2'b00:   internal = page >= `MPS_THR_P00;
            2'b01:   internal = page >= `MPS_THR_P01;
            2'b10:   internal = page >= `MPS_THR_P10;
            default: internal = page >= `MPS_THR_P11;
        endcase
    end

    // ram placement from size code
    always_comb begin
        case (ram_sw)
            3'b000:  ram_reset_base = `MPS_RAM_B000;
            3'b001:  ram_reset_base = `MPS_RAM_B001;
            3'b010:  ram_reset_base = `MPS_RAM_B010;
            3'b011:  ram_reset_base = `MPS_RAM_B011;
            3'b100:  ram_reset_base = `MPS_RAM_B100;
            3'b101:  ram_reset_base = `MPS_RAM_B101;
            3'b110:  ram_reset_base = `MPS_RAM_B110;
            default: ram_reset_base = `MPS_RAM_B111;
        endcase
        case (ram_sw)
            3'b000:  ram_pos_lsb = 4'hb;
            3'b001:  ram_pos_lsb = 4'hc;
            3'b010,
            3'b011:  ram_pos_lsb = 4'hd;
            default: ram_pos_lsb = 4'he;
        endcase
    end

    // only codes smaller than their region care about alignment
    assign ram_align_high = ram_high_align &&
        (ram_sw == 3'b010 || ram_sw == 3'b100 ||
         ram_sw == 3'b101 || ram_sw == 3'b110);

    // fixed space in 16K units: 0, 1, 3, 4
    assign fixed_16k_units = (rom_sw == 2'b00) ? 3'h0 :
                             (rom_sw == 2'b01) ? 3'h1 :
                             (rom_sw == 2'b10) ? 3'h3 : 3'h4;
    assign lower_half_blocked = rom_sw[1] && flash_upper_half_only;
endmodule : mps_window_decode

// ### dv/mps_cpu_model.sv
`timescale 1ns/1ps
module mps_cpu_model (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // commands from the bench
    input  wire logic               do_call,
    input  wire logic               do_ret,
    input  wire mps_pkg::mps_page_t call_target,
    // private page path
    input  wire mps_pkg::mps_page_t call_rd_data,
    output logic                    call_wr_en,
    output mps_pkg::mps_page_t      call_wr_data
);
    import mps_pkg::*;

    mps_page_t saved_q;

    ////////////////////////////////////////////////////////////////////////
    // call saves the old page, return restores it, each one pulse long
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call_wr_en   <= 1'b0;
            call_wr_data <= 6'h00;
            saved_q      <= 6'h00;
        end else begin
            call_wr_en <= do_call | do_ret;
            if (do_call) begin
                saved_q      <= call_rd_data;
                call_wr_data <= call_target;
            end else if (do_ret) begin
                call_wr_data <= saved_q;
            end else begin
                // data is meaningless outside the pulse, so keep it moving
                call_wr_data <= ~call_wr_data;
            end
        end
    end
endmodule : mps_cpu_model

// ### dv/memory_size_and_program_page_regs_tb.sv
`timescale 1ns/1ps
module memory_size_and_program_page_regs_tb;
    import mps_pkg::*;

    logic        pclk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    mps_addr_t   paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr;
    logic        regsw = 1'b0, rom_hi = 1'b0, rom_lo = 1'b0;
    logic        pag_hi = 1'b0, pag_lo = 1'b0;
    logic [1:0]  eep = 2'h0;
    logic [2:0]  ram = 3'h0;
    logic        spc = 1'b0, rha = 1'b0, fuho = 1'b0;
    logic        do_call = 1'b0, do_ret = 1'b0;
    mps_page_t   tgt = 6'h00, cwd, crd, ppi, ppi2;
    logic        cwe, inl, alh, lhb;
    logic [15:0] rbase;
    logic [3:0]  plsb;
    logic [2:0]  units;
    int          n_fail = 0, checked = 0;

    always #4 pclk = ~pclk;

    mps_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'h1), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .register_space_switch(regsw), .eeprom_alloc_switch(eep),
        .ram_alloc_switch(ram), .fixed_space_alloc_switch_hi(rom_hi),
        .fixed_space_alloc_switch_lo(rom_lo),
        .paging_partition_switch_hi(pag_hi),
        .paging_partition_switch_lo(pag_lo), .special_mode(spc),
        .ram_high_align(rha), .flash_upper_half_only(fuho),
        .call_wr_en(cwe), .call_wr_data(cwd), .call_rd_data(crd),
        .program_page_index(ppi), .page_window_internal(inl),
        .ram_reset_base(rbase), .ram_pos_lsb(plsb), .ram_align_high(alh),
        .fixed_16k_units(units), .lower_half_blocked(lhb));

    // second copy with the special-mode-only write option
    mps_regs #(.PAGE_WR_SPECIAL_ONLY(1'b1)) spc_u (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(),
        .pready(), .pslverr(), .register_space_switch(regsw),
        .eeprom_alloc_switch(eep), .ram_alloc_switch(ram),
        .fixed_space_alloc_switch_hi(rom_hi),
        .fixed_space_alloc_switch_lo(rom_lo),
        .paging_partition_switch_hi(pag_hi),
        .paging_partition_switch_lo(pag_lo), .special_mode(spc),
        .ram_high_align(rha), .flash_upper_half_only(fuho),
        .call_wr_en(1'b0), .call_wr_data(6'h00), .call_rd_data(),
        .program_page_index(ppi2), .page_window_internal(),
        .ram_reset_base(), .ram_pos_lsb(), .ram_align_high(),
        .fixed_16k_units(), .lower_half_blocked());

    mps_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .do_call(do_call),
        .do_ret(do_ret), .call_target(tgt), .call_rd_data(crd),
        .call_wr_en(cwe), .call_wr_data(cwd));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk

    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input mps_addr_t a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    task automatic t_size_a();
        logic [15:0] base [8] = '{16'h0800, 16'h0000, 16'h0800, 16'h0000,
                                  16'h1800, 16'h1000, 16'h0800, 16'h0000};
        logic [3:0]  lsb [8] = '{4'hb, 4'hc, 4'hd, 4'hd, 4'he, 4'he,
                                 4'he, 4'he};
        for (int i = 0; i < 8; i++) begin
            regsw <= i[0];
            rha <= i[0];
            eep <= i[2:1];
            ram <= i[2:0];
            apb(1'b1, 12'h000, 32'h0000_00ff);
            apb(1'b0, 12'h000, 32'h0);
            chk("size_a", {24'h0, i[0], 1'b0, i[2:1], 1'b0, i[2:0]}, q);
            chk("ram_base", base[i], rbase);
            chk("ram_lsb", lsb[i], plsb);
            // only code 101 is both partial and aligned high here
            chk("align", i == 5, alh);
        end
        $display("size_a test done");
    endtask : t_size_a

    task automatic t_size_b();
        logic [2:0] u [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            {rom_hi, rom_lo} <= i[1:0];
            {pag_hi, pag_lo} <= ~i[1:0];
            fuho <= 1'b1;
            apb(1'b1, 12'h004, 32'h0000_003c);
            apb(1'b0, 12'h004, 32'h0);
            chk("size_b", {24'h0, i[1:0], 4'h0, ~i[1:0]}, q);
            chk("units", u[i], units);
            chk("blocked", i[1], lhb);
            fuho <= 1'b0;
            @(posedge pclk);
            #1 chk("blocked_off", 1'b0, lhb);
        end
        $display("size_b test done");
    endtask : t_size_b

    // page update lands one cycle after the access edge
    task automatic t_page();
        chk("page_rst", 6'h00, ppi);
        chk("page_rst_spc", 6'h3c, ppi2);
        apb(1'b1, 12'h008, 32'h0000_00ff);
        #1 chk("page_old", 6'h00, ppi);
        @(posedge pclk);
        #1 chk("page_new", 6'h3f, ppi);
        chk("page_locked", 6'h3c, ppi2);
        apb(1'b0, 12'h008, 32'h0);
        chk("page_rd", 32'h0000_003f, q);
        // special mode opens the page for the restricted option
        spc <= 1'b1;
        apb(1'b1, 12'h008, 32'h0000_0015);
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("page_spc", 6'h15, ppi2);
        chk("slverr", 1'b0, pslverr);
        $display("page test done");
    endtask : t_page

    task automatic t_window();
        mps_page_t thr [4] = '{6'h38, 6'h30, 6'h20, 6'h00};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            {pag_hi, pag_lo} <= i[1:0];
            apb(1'b1, 12'h008, {26'h0, thr[i]});
            @(posedge pclk);
            #1 chk("internal", 1'b1, inl);
            apb(1'b1, 12'h008, {26'h0, thr[i] - 6'h01});
            @(posedge pclk);
            #1 chk("page_bin", 6'(thr[i] - 6'h01), ppi);
            chk("internal_lo", i == 3, inl);
        end
        $display("window test done");
    endtask : t_window

    task automatic t_call();
        apb(1'b1, 12'h008, 32'h0000_0005);
        @(posedge pclk);
        tgt <= 6'h2a;
        do_call <= 1'b1;
        @(posedge pclk);
        do_call <= 1'b0;
        @(posedge pclk);
        #1 chk("call_page", 6'h2a, ppi);
        chk("call_rd", 6'h2a, crd);
        @(posedge pclk);
        do_ret <= 1'b1;
        @(posedge pclk);
        do_ret <= 1'b0;
        @(posedge pclk);
        #1 chk("ret_page", 6'h05, ppi);
        $display("call test done");
    endtask : t_call

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_page();
        t_size_a();
        t_size_b();
        t_window();
        t_call();
        end_of_test();
    end

    // watchdog well beyond the 150 or so cycles the tests need
    initial begin
        #20000;
        n_fail++;
        end_of_test();
    end
endmodule : memory_size_and_program_page_regs_tb
